// file: rtl/pwm_pkg.sv
// constants and carrier types shared by the three-phase pwm block
package pwm_pkg;

  // widths of the host data path and of the register fields
  localparam int unsigned DATA_W  = 12;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DT_W    = 7;
  localparam int unsigned PD_W    = 7;
  localparam int unsigned PHASES  = 3;
  localparam int unsigned TIME_W  = 13;  // one bit above the period for edge sums

  // register addresses on the four address pins
  localparam logic [3:0] ADDR_PERIOD  = 4'h0;
  localparam logic [3:0] ADDR_DUTY1   = 4'h1;
  localparam logic [3:0] ADDR_DUTY2   = 4'h2;
  localparam logic [3:0] ADDR_DUTY3   = 4'h3;
  localparam logic [3:0] ADDR_DEAD    = 4'h4;
  localparam logic [3:0] ADDR_DELETE  = 4'h5;
  localparam logic [3:0] ADDR_STATUS  = 4'h6;

  // status register field positions
  localparam int unsigned STAT_RUN_BIT    = 0;
  localparam int unsigned STAT_ARMED_BIT  = 1;
  localparam int unsigned STAT_STOP_BIT   = 2;
  localparam int unsigned STAT_PEND_LSB   = 3;  // three bits of pending duty writes

  // reset values
  localparam logic [11:0] RESET_PERIOD = 12'h000;
  localparam logic [11:0] RESET_DUTY   = 12'h000;
  localparam logic [6:0]  RESET_DEAD   = 7'h00;
  localparam logic [6:0]  RESET_DELETE = 7'h00;

  // timing counts
  localparam logic [11:0] CALC_LEAD    = 12'h004;  // cycles before period start for edge calc
  localparam logic [11:0] MIN_PERIOD   = 12'h008;  // shortest period the pipeline can serve
  localparam int unsigned SYNC_STAGES  = 3;

  // host strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } strobe_s;

  // one phase leg, both gate drives active low
  typedef struct packed {
    logic main_n;
    logic comp_n;
  } leg_s;

  // edge times of one channel for one period
  typedef struct packed {
    logic [TIME_W-1:0] main_on;    // main turns on here
    logic [TIME_W-1:0] main_off;   // main turns off here
    logic [TIME_W-1:0] comp_stop;  // complement on before this
    logic [TIME_W-1:0] comp_back;  // complement on again from this
    logic              deleted;    // pulse suppressed this period
  } edges_s;

endpackage : pwm_pkg

// file: rtl/pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         clock_en,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  // stage one feeds stage two only; output follows once two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
        begin
          s1_q[g]    <= RESET_VAL[g];
          s2_q[g]    <= RESET_VAL[g];
          s3_q[g]    <= RESET_VAL[g];
          level_q[g] <= RESET_VAL[g];
        end
        else if (clock_en)
        begin
          s1_q[g] <= pin[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g])
            level_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  assign level = level_q;

endmodule : pin_sync

`default_nettype wire

// file: rtl/three_phase_center_pwm.sv
// three-phase center-based pwm with deadtime, pulse deletion and shutdown
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - three centered 12-bit pulses, each complemented with deadtime, six outputs.
// - period in clock cycles equals the switching period register value.
// - edges fall on whole system clock cycles.
// - all six gate outputs are active low.
// - sync output pulses one clock wide at every period start.
// - duty register holds on-time in clocks; density is duty over period.
// - new duties apply only after all three are rewritten.
// - edges for next period computed in the last four clocks of the current one.
// - deadtime is 7 bits with bit zero forced low, even 0 to 126.
// - deadtime separates complementary edges so a leg never conducts twice.
// - pulses shorter than deletion value give main off, complement on.
// - shutdown high forces all six gate outputs high within one clock.
// - shutdown low re-enables outputs within one clock.
module three_phase_center_pwm #(
  parameter int unsigned DATA_W = pwm_pkg::DATA_W,
  parameter int unsigned TIME_W = pwm_pkg::TIME_W
) (
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic                    clock_en,
  input  wire logic                    cs_n,
  input  wire logic                    rd_n,
  input  wire logic                    wr_n,
  input  wire logic [pwm_pkg::ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0]       data_in,
  output logic      [DATA_W-1:0]       data_out,
  output logic                         data_oe,
  input  wire logic                    shutdown,
  output pwm_pkg::leg_s                leg_one,
  output pwm_pkg::leg_s                leg_two,
  output pwm_pkg::leg_s                leg_three,
  output logic                         cycle_sync_pulse
);

  localparam int unsigned NPH = pwm_pkg::PHASES;

  // synchronised host strobes
  pwm_pkg::strobe_s strobe_raw;
  pwm_pkg::strobe_s strobe;
  pwm_pkg::strobe_s strobe_prev_q;

  // host registers
  logic [DATA_W-1:0]        period_q;
  logic [DATA_W-1:0]        duty_q [NPH];
  logic [pwm_pkg::DT_W-1:0] dead_q;
  logic [pwm_pkg::PD_W-1:0] delete_q;
  logic [NPH-1:0]           written_q;   // duties rewritten since last apply
  logic                     period_seen_q;

  // counter and period control
  logic                     running_q;
  logic                     armed_q;
  logic                     fresh_q;
  logic [DATA_W-1:0]        period_act_q;
  logic [DATA_W-1:0]        period_next_q;
  logic [DATA_W-1:0]        cnt_q;
  logic [pwm_pkg::DT_W-1:0] dead_next_q;
  logic [pwm_pkg::PD_W-1:0] delete_next_q;

  // decode and strobes
  logic             write_take;
  logic             read_active;
  logic [NPH-1:0]   write_hit;
  logic             all_written;
  logic             at_a;
  logic             at_b;
  logic             at_c;
  logic             at_wrap;
  logic             stop_level;
  logic [DATA_W-1:0] rd_data_q;
  logic [TIME_W-1:0] t_now;

  pwm_pkg::leg_s    leg_q [NPH];
  logic             sync_q;

  // pick a duty register index for an address, or none
  function automatic logic [NPH-1:0] duty_sel(input logic [pwm_pkg::ADDR_W-1:0] a);
    logic [NPH-1:0] s;
    s = '0;
    if (a == pwm_pkg::ADDR_DUTY1)
      s[0] = 1'b1;
    else if (a == pwm_pkg::ADDR_DUTY2)
      s[1] = 1'b1;
    else if (a == pwm_pkg::ADDR_DUTY3)
      s[2] = 1'b1;
    return s;
  endfunction : duty_sel

  // host strobe pins pass the three-stage synchroniser
  assign strobe_raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n};

  pin_sync #(
    .W         (3),
    .RESET_VAL (3'h7)
  ) u_strobe_sync (
    .clock    (clock),
    .resetn   (resetn),
    .clock_en (clock_en),
    .pin      (strobe_raw),
    .level    (strobe)
  );

  // shutdown level for status read-back only
  pin_sync #(
    .W         (1),
    .RESET_VAL (1'b0)
  ) u_stop_sync (
    .clock    (clock),
    .resetn   (resetn),
    .clock_en (clock_en),
    .pin      (shutdown),
    .level    (stop_level)
  );

  // remember last strobe levels for edge detection
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      strobe_prev_q <= 3'h7;
    else if (clock_en)
      strobe_prev_q <= strobe;
  end

  // a write is taken at the rising edge of the write strobe under chip select
  assign write_take  = strobe.wr_n && !strobe_prev_q.wr_n && !strobe_prev_q.cs_n;
  assign read_active = !strobe.cs_n && !strobe.rd_n;
  assign write_hit   = write_take ? duty_sel(addr) : '0;
  assign all_written = &written_q;

  // pipeline positions in the last four clocks of a period
  assign at_a    = running_q && (cnt_q == period_act_q - pwm_pkg::CALC_LEAD);
  assign at_b    = running_q && (cnt_q == period_act_q - 12'h003);
  assign at_c    = running_q && (cnt_q == period_act_q - 12'h002);
  assign at_wrap = running_q && (cnt_q == period_act_q - 12'h001);
  assign t_now   = {1'b0, cnt_q};

  // period, deadtime and deletion registers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      period_q      <= pwm_pkg::RESET_PERIOD;
      dead_q        <= pwm_pkg::RESET_DEAD;
      delete_q      <= pwm_pkg::RESET_DELETE;
      period_seen_q <= 1'b0;
    end
    else if (clock_en && write_take)
    begin
      if (addr == pwm_pkg::ADDR_PERIOD)
      begin
        period_q      <= data_in;
        period_seen_q <= 1'b1;
      end
      else if (addr == pwm_pkg::ADDR_DEAD)
        dead_q <= {data_in[pwm_pkg::DT_W-1:1], 1'b0};
      else if (addr == pwm_pkg::ADDR_DELETE)
        delete_q <= data_in[pwm_pkg::PD_W-1:0];
    end
  end

  // duty registers and their rewritten marks
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NPH; i++)
        duty_q[i] <= pwm_pkg::RESET_DUTY;
      written_q <= '0;
    end
    else if (clock_en)
    begin
      for (int i = 0; i < NPH; i++)
        if (write_hit[i])
          duty_q[i] <= data_in;
      // marks clear on apply, a same-cycle write keeps its mark
      if (at_a && all_written)
        written_q <= write_hit;
      else
        written_q <= written_q | write_hit;
    end
  end

  // free-running counter over the active period
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      running_q    <= 1'b0;
      cnt_q        <= '0;
      period_act_q <= pwm_pkg::RESET_PERIOD;
    end
    else if (clock_en)
    begin
      if (!running_q)
      begin
        if (period_seen_q && period_q >= pwm_pkg::MIN_PERIOD)
        begin
          running_q    <= 1'b1;
          cnt_q        <= '0;
          period_act_q <= period_q;
        end
      end
      else if (at_wrap)
      begin
        cnt_q        <= '0;
        period_act_q <= period_next_q;
      end
      else
        cnt_q <= cnt_q + 12'h001;
    end
  end

  // snapshot of settings for the coming period at four clocks ahead
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      period_next_q <= pwm_pkg::RESET_PERIOD;
      dead_next_q   <= pwm_pkg::RESET_DEAD;
      delete_next_q <= pwm_pkg::RESET_DELETE;
      fresh_q       <= 1'b0;
      armed_q       <= 1'b0;
    end
    else if (clock_en)
    begin
      if (at_a)
      begin
        // an invalid new period is ignored, the old one keeps running
        period_next_q <= (period_q >= pwm_pkg::MIN_PERIOD) ? period_q : period_act_q;
        dead_next_q   <= dead_q;
        delete_next_q <= delete_q;
        fresh_q       <= armed_q || all_written;
      end
      // outputs enabled only after a full duty set reaches the edges
      if (at_wrap)
        armed_q <= fresh_q;
    end
  end

  // per-channel edge pipeline and output stage
  genvar ch;
  generate
    for (ch = 0; ch < NPH; ch++)
    begin : g_chan
      logic [DATA_W-1:0] duty_app_q;   // duty in force
      logic [TIME_W-1:0] work_q;       // clamped on-time
      logic [TIME_W-1:0] start_q;      // centred start point
      logic              del_q;
      pwm_pkg::edges_s   calc_q;
      pwm_pkg::edges_s   live_q;
      logic              main_on;
      logic              comp_on;
      logic [DATA_W-1:0] duty_pick;

      // take the new duty only when the whole set was rewritten
      assign duty_pick = all_written ? duty_q[ch] : duty_app_q;

      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
        begin
          duty_app_q <= pwm_pkg::RESET_DUTY;
          work_q     <= '0;
          start_q    <= '0;
          del_q      <= 1'b0;
          calc_q     <= '0;
          live_q     <= '0;
        end
        else if (clock_en)
        begin
          // on-time clamps to the period so density tops at one
          if (at_a)
          begin
            duty_app_q <= duty_pick;
            work_q     <= (duty_pick > period_q && period_q >= pwm_pkg::MIN_PERIOD)
                          ? {1'b0, period_q}
                          : {1'b0, duty_pick};
          end
          // half the off-time before the pulse centres it
          if (at_b)
          begin
            // an over-long on-time centres at zero instead of wrapping below it
            start_q <= (work_q > {1'b0, period_next_q}) ? '0
                       : ({1'b0, period_next_q} - work_q) >> 1;
            del_q   <= work_q < {6'h00, delete_next_q};
            if (work_q > {1'b0, period_next_q})
              work_q <= {1'b0, period_next_q};
          end
          // deadtime delays each turn-on after the partner's turn-off
          if (at_c)
          begin
            calc_q.main_on   <= start_q + {6'h00, dead_next_q};
            calc_q.main_off  <= start_q + work_q;
            calc_q.comp_stop <= start_q;
            calc_q.comp_back <= start_q + work_q + {6'h00, dead_next_q};
            calc_q.deleted   <= del_q;
          end
          if (at_wrap)
            live_q <= calc_q;
        end
      end

      // main pulse and its complement from the same edge set
      assign main_on = !live_q.deleted && t_now >= live_q.main_on && t_now < live_q.main_off;
      assign comp_on = live_q.deleted || t_now < live_q.comp_stop || t_now >= live_q.comp_back;

      // low drives the switch on; idle and stopped legs sit high
      always_ff @(posedge clock or negedge resetn)
      begin
        if (!resetn)
          leg_q[ch] <= 2'b11;
        else if (clock_en)
        begin
          // shutdown forces high at the next edge
          // release also takes effect at the next edge
          leg_q[ch].main_n <= !(running_q && armed_q && main_on) || shutdown;
          leg_q[ch].comp_n <= !(running_q && armed_q && comp_on) || shutdown;
        end
      end
    end
  endgenerate

  // outputs and sync are registered on every clock edge with clock_en high
  // sync marks count zero for exactly one clock
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sync_q <= 1'b0;
    else if (clock_en)
      sync_q <= running_q && (cnt_q == 12'h000);
  end

  // read data registered every enabled cycle from the address pins
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rd_data_q <= '0;
    else if (clock_en)
    begin
      if (addr == pwm_pkg::ADDR_PERIOD)
        rd_data_q <= period_q;
      else if (addr == pwm_pkg::ADDR_DUTY1)
        rd_data_q <= duty_q[0];
      else if (addr == pwm_pkg::ADDR_DUTY2)
        rd_data_q <= duty_q[1];
      else if (addr == pwm_pkg::ADDR_DUTY3)
        rd_data_q <= duty_q[2];
      else if (addr == pwm_pkg::ADDR_DEAD)
        rd_data_q <= {5'h00, dead_q};
      else if (addr == pwm_pkg::ADDR_DELETE)
        rd_data_q <= {5'h00, delete_q};
      else if (addr == pwm_pkg::ADDR_STATUS)
        rd_data_q <= {6'h00, written_q, stop_level, armed_q, running_q};
      else
        rd_data_q <= '0;
    end
  end

  assign data_out         = rd_data_q;
  assign data_oe          = read_active;
  assign leg_one          = leg_q[0];
  assign leg_two          = leg_q[1];
  assign leg_three        = leg_q[2];
  assign cycle_sync_pulse = sync_q;

endmodule : three_phase_center_pwm

`default_nettype wire

// file: testbench/gate_drive_model.sv
// power switch model standing behind the six gate outputs
`timescale 1ns/1ps
`default_nettype none
module gate_drive_model (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire pwm_pkg::leg_s leg_one,
  input  wire pwm_pkg::leg_s leg_two,
  input  wire pwm_pkg::leg_s leg_three,
  output logic [5:0]         switch_on,
  output logic               overlap_seen
);
  // low gate level closes the switch
  assign switch_on = ~{leg_one, leg_two, leg_three};
  // both switches of one leg closed would short the supply
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      overlap_seen <= 1'b0;
    else if (&switch_on[5:4] || &switch_on[3:2] || &switch_on[1:0])
      overlap_seen <= 1'b1;
  end
endmodule : gate_drive_model
`default_nettype wire

// file: testbench/pwm_checker.sv
// timing assertions on the pwm outputs
`timescale 1ns/1ps
`default_nettype none
module pwm_checker (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          shutdown,
  input  wire pwm_pkg::leg_s leg_one,
  input  wire pwm_pkg::leg_s leg_two,
  input  wire pwm_pkg::leg_s leg_three,
  input  wire logic          cycle_sync_pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic all_idle;
  logic seen_sync_q;
  // all six gates inactive
  assign all_idle = ({leg_one, leg_two, leg_three} == 6'h3f);
  // remembers that the counter has started
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      seen_sync_q <= 1'b0;
    else if (cycle_sync_pulse)
      seen_sync_q <= 1'b1;
  end
  sequence sync_then_quiet;
    cycle_sync_pulse ##1 !cycle_sync_pulse [*7];
  endsequence
  a_sync_one_wide: assert property (cycle_sync_pulse |=> !cycle_sync_pulse)
    else $error("sync pulse wider than one clock");
  a_sync_min_gap: assert property (cycle_sync_pulse |-> sync_then_quiet)
    else $error("sync pulses closer than shortest period");
  a_stop_forces_idle: assert property (shutdown |=> all_idle)
    else $error("gates active one clock after shutdown");
  a_leg_one_apart: assert property (leg_one != 2'b00)
    else $error("leg one both on");
  a_leg_two_apart: assert property (leg_two != 2'b00)
    else $error("leg two both on");
  a_leg_three_apart: assert property (leg_three != 2'b00)
    else $error("leg three both on");
  a_reset_idle_out: assert property ($rose(resetn) |-> all_idle && !cycle_sync_pulse)
    else $error("outputs active at reset release");
  a_unstarted_idle: assert property (!seen_sync_q |-> all_idle)
    else $error("gates active before counter start");
endmodule : pwm_checker
bind three_phase_center_pwm pwm_checker pwm_checker_inst (.clock(clock), .resetn(resetn),
  .shutdown(shutdown), .leg_one(leg_one), .leg_two(leg_two), .leg_three(leg_three),
  .cycle_sync_pulse(cycle_sync_pulse));
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the three-phase pwm block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PER = 20;
  logic          clock, resetn, cs_n, rd_n, wr_n, shutdown, data_oe, sync, overlap_seen;
  logic [3:0]    addr;
  logic [11:0]   data_in, data_out, rdat;
  logic [5:0]    switch_on;
  logic          clock_en;
  pwm_pkg::leg_s leg_one, leg_two, leg_three;
  int            failures, check_count, cycles, mlow[3], clow[3], mfirst[3];
  three_phase_center_pwm three_phase_center_pwm_inst (.clock(clock), .resetn(resetn),
    .clock_en(clock_en), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .shutdown(shutdown), .leg_one(leg_one),
    .leg_two(leg_two), .leg_three(leg_three), .cycle_sync_pulse(sync));
  gate_drive_model gate_drive_model_inst (.clock(clock), .resetn(resetn), .leg_one(leg_one),
    .leg_two(leg_two), .leg_three(leg_three), .switch_on(switch_on),
    .overlap_seen(overlap_seen));
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : check
  // strobes held long enough for the pin filter
  task automatic reg_write(input logic [3:0] a, input logic [11:0] d);
    @(posedge clock); #1 cs_n = 0; wr_n = 0; addr = a; data_in = d;
    repeat (5) @(posedge clock); #1 wr_n = 1;
    repeat (6) @(posedge clock); #1 cs_n = 1;
    repeat (5) @(posedge clock);
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [11:0] d);
    int n;
    n = 0;
    @(posedge clock); #1 cs_n = 0; rd_n = 0; addr = a;
    while (data_oe !== 1'b1 && n < 10)
    begin
      @(posedge clock); #1 n++;
    end
    // a read enable that never rises counts as a mismatch
    if (n == 10)
      failures++;
    @(posedge clock); #1 d = data_out; rd_n = 1; cs_n = 1;
    repeat (5) @(posedge clock);
  endtask : reg_read
  task automatic wait_sync();
    int n;
    n = 0;
    while (sync !== 1'b1 && n < 200)
    begin
      @(posedge clock); #1 n++;
    end
    // a sync pulse that never comes counts as a mismatch
    if (n == 200)
      failures++;
  endtask : wait_sync
  // counts low gate cycles over one whole period from a sync pulse
  task automatic measure();
    pwm_pkg::leg_s lg[3];
    int extra;
    extra = 0;
    mlow = '{0, 0, 0};
    clow = '{0, 0, 0};
    mfirst = '{-1, -1, -1};
    wait_sync();
    for (int k = 0; k < PER; k++)
    begin
      lg = '{leg_one, leg_two, leg_three};
      if (k > 0 && sync !== 1'b0) extra++;
      for (int i = 0; i < 3; i++)
      begin
        if (lg[i].main_n === 1'b0 && mfirst[i] < 0) mfirst[i] = k;
        if (lg[i].main_n === 1'b0) mlow[i]++;
        if (lg[i].comp_n === 1'b0) clow[i]++;
      end
      @(posedge clock); #1;
    end
    check(12'(extra), 12'h000, "sync inside period");
    check({11'h000, sync}, 12'h001, "sync after period");
  endtask : measure
  // expected pulse from duty, deadtime and deletion value
  task automatic expect_legs(input int d0, input int d1, input int d2, input int dt,
                             input int del);
    int st;
    int d[3];
    d = '{d0, d1, d2};
    for (int i = 0; i < 3; i++)
    begin
      st = (PER - d[i]) >> 1;
      check(12'(mlow[i]), 12'(d[i] < del ? 0 : d[i] - dt), "main low");
      check(12'(clow[i]), 12'(d[i] < del ? PER : PER - d[i] - dt), "comp low");
      check(12'(mfirst[i]), 12'(d[i] < del ? -1 : st + dt), "main start");
    end
  endtask : expect_legs
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      stop_test();
    end
  end
  initial
  begin
    resetn = 0; cs_n = 1; rd_n = 1; wr_n = 1; shutdown = 0; addr = 4'h0; data_in = 12'h000;
    failures = 0; check_count = 0; cycles = 0;
    clock_en = 1;
    repeat (4) @(posedge clock);
    #1 resetn = 1;
    for (int a = 0; a < 8; a++)
    begin
      reg_read(4'(a), rdat);
      check(rdat, 12'h000, "reset register");
    end
    check({6'h00, leg_one, leg_two, leg_three}, 12'h03f, "reset legs");
    $display("test reset done");
    reg_write(pwm_pkg::ADDR_PERIOD, 12'h014);
    reg_write(pwm_pkg::ADDR_DEAD, 12'h003);
    reg_write(pwm_pkg::ADDR_DELETE, 12'h005);
    reg_read(pwm_pkg::ADDR_DEAD, rdat);
    check(rdat, 12'h002, "deadtime bit zero");
    reg_read(pwm_pkg::ADDR_PERIOD, rdat);
    check(rdat, 12'h014, "period readback");
    measure();
    for (int i = 0; i < 3; i++) check(12'(mlow[i] + clow[i]), 12'h000, "unarmed");
    $display("test period only done");
    // whole duty set written, settled before measuring
    reg_write(pwm_pkg::ADDR_DUTY1, 12'h00a);
    reg_write(pwm_pkg::ADDR_DUTY2, 12'h004);
    reg_write(pwm_pkg::ADDR_DUTY3, 12'h010);
    measure();
    measure();
    expect_legs(10, 4, 16, 2, 5);
    $display("test duty set done");
    reg_write(pwm_pkg::ADDR_DUTY1, 12'h006);
    measure();
    measure();
    expect_legs(10, 4, 16, 2, 5);
    reg_write(pwm_pkg::ADDR_DUTY2, 12'h00c);
    reg_write(pwm_pkg::ADDR_DUTY3, 12'h005);
    measure();
    measure();
    expect_legs(6, 12, 5, 2, 5);
    $display("test partial update done");
    // clock enable low holds the counter for 19 clocks with no sync
    wait_sync();
    @(posedge clock);
    #1;
    clock_en = 0;
    repeat (19) @(posedge clock);
    #1;
    check({6'h00, leg_one, leg_two, leg_three}, 12'h02a, "frozen legs");
    check({11'h000, sync}, 12'h000, "frozen sync");
    clock_en = 1;
    $display("test clock enable done");
    wait_sync();
    @(posedge clock); #1 shutdown = 1;
    @(posedge clock); #1;
    check({6'h00, leg_one, leg_two, leg_three}, 12'h03f, "stop idle");
    repeat (7) @(posedge clock); #1 shutdown = 0;
    @(posedge clock); #1;
    check({10'h000, leg_one}, 12'h001, "stop release");
    check({11'h000, overlap_seen}, 12'h000, "shoot-through");
    $display("test shutdown done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
